// [rtl/i2ctc_pkg.sv]
// constants, types and state encodings of the serial-bus target controller
// assumes a software-side clock and a separate link clock for the bus logic
package i2ctc_pkg;

  localparam int BYTE_W = 8;
  localparam int EVT_N = 4;

  // bus address byte with the direction bit clear, and general call byte
  localparam logic [7:0] OWN_ADDR_BYTE = 8'h6C;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int RNW_POS = 0;
  localparam int MSB_POS = 7;

  // bit counter
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // event lanes from link to software domain
  localparam int EV_AM = 0;
  localparam int EV_RX = 1;
  localparam int EV_STOP = 2;
  localparam int EV_TAKE = 3;

  // bus lines idle high
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK,
    ST_WAIT_STOP
  } i2ctc_state_type;

  typedef struct packed {
    logic addr_match_flag;
    logic rx_buffer_full_flag;
    logic stop_flag;
    logic read_direction_flag;
    logic tx_buffer_full_flag;
    logic overflow_flag;
  } i2ctc_status_type;

  typedef struct packed {
    logic clock_pin_pull_ctrl_a;
    logic clock_pin_pull_ctrl_b;
    logic data_pin_pull_ctrl_a;
    logic data_pin_pull_ctrl_b;
  } i2ctc_pull_type;

  // pin setup of the application code, used while the interface is off
  typedef struct packed {
    logic clock_pin_dir;
    logic clock_pin_out;
    logic data_pin_dir;
    logic data_pin_out;
  } i2ctc_pin_cfg_type;

endpackage : i2ctc_pkg

// [rtl/i2ctc_pin_sync.sv]
// three-stage synchroniser with agreement filter for a level
// assumes an asynchronous source; output changes once stages two and three agree
module i2ctc_pin_sync
  import i2ctc_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // level
  input wire logic async_i,
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      level_q <= RESET_VAL;
    else if (s2_q == s3_q)
      level_q <= s2_q;
  end

  assign level_o = level_q;

endmodule : i2ctc_pin_sync

// [rtl/i2ctc_evt_sync.sv]
// toggle-to-pulse event crossing
// assumes the source toggles at most once per several destination cycles
module i2ctc_evt_sync
  import i2ctc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // event
  input wire logic toggle_i,
  output logic pulse_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= toggle_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign pulse_o = s2_q ^ s3_q;

endmodule : i2ctc_evt_sync

// [rtl/i2ctc_top.sv]
// serial-bus target controller: bus engine on the link clock, flags and data register on ref_clk_i
// assumes an external master drives the clock line; lines have pull-ups; link clock well above bus rate
module i2ctc_top
  import i2ctc_pkg::*;
(
  // clocks and reset
  input wire logic ref_clk_i,
  input wire logic bus_clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic bus_iface_enable_i,
  input wire logic general_call_enable_i,
  input wire logic power_down_i,
  input wire i2ctc_pull_type pull_ctrl_i,
  input wire i2ctc_pin_cfg_type app_pin_cfg_i,
  // data register and flags
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [BYTE_W-1:0] data_wdata_i,
  output logic [BYTE_W-1:0] bus_data_reg_o,
  input wire i2ctc_status_type flag_clear_i,
  output i2ctc_status_type bus_status_reg_o,
  // clock pin
  input wire logic clock_port_pin_i,
  output logic clock_port_pin_o,
  output logic clock_port_pin_oe_o,
  output logic clock_pin_pullup_o,
  // data pin
  input wire logic data_port_pin_i,
  output logic data_port_pin_o,
  output logic data_port_pin_oe_o,
  output logic data_pin_pullup_o
);

  ////////////////////////////////////////////////////////////////////////////
  // software domain: enable, pins, pull-ups

  logic active_q;
  logic clk_pull_q;
  logic dat_pull_q;
  logic sda_drv_q;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      active_q <= 1'b0;
    else
      active_q <= bus_iface_enable_i & ~power_down_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_pull_q <= 1'b0;
      dat_pull_q <= 1'b0;
    end
    else
    begin
      clk_pull_q <= pull_ctrl_i.clock_pin_pull_ctrl_a & pull_ctrl_i.clock_pin_pull_ctrl_b;
      dat_pull_q <= pull_ctrl_i.data_pin_pull_ctrl_a & pull_ctrl_i.data_pin_pull_ctrl_b;
    end
  end

  assign clock_pin_pullup_o = clk_pull_q;
  assign data_pin_pullup_o = dat_pull_q;
  // active: clock pin input, data pin only pulled low; else application setup
  assign clock_port_pin_oe_o = active_q ? 1'b0 : app_pin_cfg_i.clock_pin_dir;
  assign clock_port_pin_o = active_q ? 1'b0 : app_pin_cfg_i.clock_pin_out;
  assign data_port_pin_oe_o = active_q ? sda_drv_q : app_pin_cfg_i.data_pin_dir;
  assign data_port_pin_o = active_q ? 1'b0 : app_pin_cfg_i.data_pin_out;

  ////////////////////////////////////////////////////////////////////////////
  // crossings

  logic scl_f;
  logic sda_f;
  logic en_l;
  logic gc_l;
  logic tbf_l;
  logic tbf_q;
  logic wr_tgl_q;
  logic [EVT_N-1:0] evt_tgl_q;
  logic [EVT_N-1:0] evt_pulse;

  i2ctc_pin_sync #(.RESET_VAL(LINE_IDLE)) u_scl_sync
  (
    .clk_i(bus_clk_i),
    .rst_i(rst_i),
    .async_i(clock_port_pin_i),
    .level_o(scl_f)
  );

  i2ctc_pin_sync #(.RESET_VAL(LINE_IDLE)) u_sda_sync
  (
    .clk_i(bus_clk_i),
    .rst_i(rst_i),
    .async_i(data_port_pin_i),
    .level_o(sda_f)
  );

  i2ctc_pin_sync #(.RESET_VAL(1'b0)) u_en_sync
  (
    .clk_i(bus_clk_i),
    .rst_i(rst_i),
    .async_i(active_q),
    .level_o(en_l)
  );

  i2ctc_pin_sync #(.RESET_VAL(1'b0)) u_gc_sync
  (
    .clk_i(bus_clk_i),
    .rst_i(rst_i),
    .async_i(general_call_enable_i),
    .level_o(gc_l)
  );

  i2ctc_pin_sync #(.RESET_VAL(1'b0)) u_tbf_sync
  (
    .clk_i(bus_clk_i),
    .rst_i(rst_i),
    .async_i(wr_tgl_q),
    .level_o(tbf_l)
  );

  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi++)
    begin : g_evt
      i2ctc_evt_sync u_evt
      (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .toggle_i(evt_tgl_q[gi]),
        .pulse_o(evt_pulse[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // link domain: bus engine

  i2ctc_state_type st_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] cnt_q;
  logic [BYTE_W-1:0] shift_q;
  logic [BYTE_W-1:0] tx_sh_q;
  logic [BYTE_W-1:0] rx_byte_q;
  logic [BYTE_W-1:0] tx_hold_q;
  logic rnw_q;
  logic mack_q;
  logic taken_q;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_done;
  logic addr_hit;
  logic aack_end;
  logic wr_done;
  logic wack_end;
  logic rd_fall;
  logic rd_done;
  logic rack_end;
  logic load_tx;
  logic tx_avail;
  logic [BYTE_W-1:0] tx_next;

  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign addr_done = (st_q == ST_ADDR) && scl_fall && (cnt_q == BYTE_BITS);
  assign addr_hit = addr_done && ((shift_q[MSB_POS:RNW_POS+1] == OWN_ADDR_BYTE[MSB_POS:RNW_POS+1])
                    || (gc_l && (shift_q == GC_ADDR_BYTE)));
  assign aack_end = (st_q == ST_ADDR_ACK) && scl_fall;
  assign wr_done = (st_q == ST_WR_DATA) && scl_fall && (cnt_q == BYTE_BITS);
  assign wack_end = (st_q == ST_WR_ACK) && scl_fall;
  assign rd_fall = (st_q == ST_RD_DATA) && scl_fall;
  assign rd_done = rd_fall && (cnt_q == BYTE_BITS);
  assign rack_end = (st_q == ST_RD_ACK) && scl_fall;
  assign load_tx = (aack_end && rnw_q) || (rack_end && mack_q);
  // byte pending while the write toggle differs from the last taken one
  assign tx_avail = tbf_l ^ taken_q;
  assign tx_next = tx_avail ? tx_hold_q : IDLE_TX_BYTE;

  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_p_q <= LINE_IDLE;
      sda_p_q <= LINE_IDLE;
    end
    else
    begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // sequencing
  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_q <= ST_IDLE;
    else if (!en_l)
      st_q <= ST_IDLE;
    else if (start_det)
      st_q <= ST_ADDR;
    else if (stop_det)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_ADDR:
          if (addr_done)
            st_q <= addr_hit ? ST_ADDR_ACK : ST_WAIT_STOP;
        ST_ADDR_ACK:
          if (aack_end)
            st_q <= rnw_q ? ST_RD_DATA : ST_WR_DATA;
        ST_WR_DATA:
          if (wr_done)
            st_q <= ST_WR_ACK;
        ST_WR_ACK:
          if (wack_end)
            st_q <= ST_WR_DATA;
        ST_RD_DATA:
          if (rd_done)
            st_q <= ST_RD_ACK;
        ST_RD_ACK:
          if (rack_end)
            st_q <= mack_q ? ST_RD_DATA : ST_WAIT_STOP;
        default:
          st_q <= st_q;
      endcase
    end
  end

  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= CNT_ZERO;
    else if (start_det || aack_end || wack_end || rack_end)
      cnt_q <= CNT_ZERO;
    else if (scl_rise && (st_q == ST_ADDR || st_q == ST_WR_DATA || st_q == ST_RD_DATA))
      cnt_q <= cnt_q + CNT_ONE;
  end

  // receive path
  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_q <= DATA_RST;
      rx_byte_q <= DATA_RST;
      rnw_q <= 1'b0;
      mack_q <= 1'b0;
    end
    else
    begin
      if (scl_rise && (st_q == ST_ADDR || st_q == ST_WR_DATA))
        shift_q <= {shift_q[MSB_POS-1:0], sda_f};
      if (wr_done)
        rx_byte_q <= shift_q;
      if (addr_hit)
        rnw_q <= shift_q[RNW_POS];
      if (scl_rise && st_q == ST_RD_ACK)
        mack_q <= ~sda_f;
    end
  end

  // transmit path
  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_sh_q <= IDLE_TX_BYTE;
      taken_q <= 1'b0;
    end
    else
    begin
      if (load_tx)
        tx_sh_q <= tx_next;
      else if (rd_fall)
        tx_sh_q <= {tx_sh_q[MSB_POS-1:0], LINE_IDLE};
      if (load_tx && tx_avail)
        taken_q <= tbf_l;
    end
  end

  // data line: pull low for acknowledge and zero bits only
  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sda_drv_q <= 1'b0;
    else if (!en_l || start_det || stop_det)
      sda_drv_q <= 1'b0;
    else if (addr_hit || wr_done)
      sda_drv_q <= 1'b1;
    else if (load_tx)
      sda_drv_q <= ~tx_next[MSB_POS];
    else if (rd_done)
      sda_drv_q <= 1'b0;
    else if (rd_fall)
      sda_drv_q <= ~tx_sh_q[MSB_POS-1];
    else if (aack_end || wack_end || (st_q == ST_ADDR && scl_fall))
      sda_drv_q <= 1'b0;
  end

  always_ff @(posedge bus_clk_i or posedge rst_i)
  begin
    if (rst_i)
      evt_tgl_q <= '0;
    else
    begin
      if (addr_hit)
        evt_tgl_q[EV_AM] <= ~evt_tgl_q[EV_AM];
      if (wr_done)
        evt_tgl_q[EV_RX] <= ~evt_tgl_q[EV_RX];
      if (stop_det && en_l)
        evt_tgl_q[EV_STOP] <= ~evt_tgl_q[EV_STOP];
      if (load_tx && tx_avail)
        evt_tgl_q[EV_TAKE] <= ~evt_tgl_q[EV_TAKE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software domain: data register and flags

  i2ctc_status_type flags_q;
  logic [BYTE_W-1:0] rx_data_q;
  logic rx_ovf;
  logic tx_ovf;

  assign rx_ovf = evt_pulse[EV_RX] & flags_q.rx_buffer_full_flag & ~data_rd_i;
  assign tx_ovf = data_wr_i & tbf_q;
  assign tbf_q = flags_q.tx_buffer_full_flag;

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_data_q <= DATA_RST;
      tx_hold_q <= DATA_RST;
      wr_tgl_q <= 1'b0;
    end
    else
    begin
      if (evt_pulse[EV_RX])
        rx_data_q <= rx_byte_q;
      if (data_wr_i && !tbf_q)
      begin
        tx_hold_q <= data_wdata_i;
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // hardware set wins over any clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_q <= '0;
    else
    begin
      if (evt_pulse[EV_AM])
        flags_q.addr_match_flag <= 1'b1;
      else if (flag_clear_i.addr_match_flag)
        flags_q.addr_match_flag <= 1'b0;
      if (evt_pulse[EV_AM])
        flags_q.read_direction_flag <= rnw_q;
      else if (flag_clear_i.read_direction_flag)
        flags_q.read_direction_flag <= 1'b0;
      if (evt_pulse[EV_RX])
        flags_q.rx_buffer_full_flag <= 1'b1;
      else if (data_rd_i)
        flags_q.rx_buffer_full_flag <= 1'b0;
      if (evt_pulse[EV_STOP])
        flags_q.stop_flag <= 1'b1;
      else if (flag_clear_i.stop_flag)
        flags_q.stop_flag <= 1'b0;
      if (data_wr_i && !tbf_q)
        flags_q.tx_buffer_full_flag <= 1'b1;
      else if (evt_pulse[EV_TAKE])
        flags_q.tx_buffer_full_flag <= 1'b0;
      if (rx_ovf || tx_ovf)
        flags_q.overflow_flag <= 1'b1;
      else if (flag_clear_i.overflow_flag)
        flags_q.overflow_flag <= 1'b0;
    end
  end

  assign bus_data_reg_o = rx_data_q;
  assign bus_status_reg_o = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  AST_ACK_ON_MATCH: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    addr_hit |=> (st_q == ST_ADDR_ACK) && sda_drv_q)
    else $error("address match not acknowledged");

  AST_NO_ACK_FOREIGN: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    addr_done && !addr_hit |=> !sda_drv_q && (st_q == ST_WAIT_STOP))
    else $error("foreign address acknowledged");

  AST_ADDR_EIGHT_BITS: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    (st_q == ST_ADDR) && scl_fall && (cnt_q != BYTE_BITS) |=> (st_q == ST_ADDR) || !en_l || $past(start_det))
    else $error("address phase left before eight bits");

  AST_WR_BYTE_ACK: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    wr_done |=> sda_drv_q && (rx_byte_q == $past(shift_q)) && (st_q == ST_WR_ACK))
    else $error("write byte not captured and acknowledged");

  AST_RD_RELEASE: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    rd_done |=> !sda_drv_q && (st_q == ST_RD_ACK))
    else $error("data line not released on ninth read clock");

  AST_DISABLED_IDLE: assert property (@(posedge bus_clk_i) disable iff (rst_i)
    !en_l |=> (st_q == ST_IDLE) && !sda_drv_q)
    else $error("engine active while disabled");

  AST_LOW_ONLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    active_q |-> !data_port_pin_o && !clock_port_pin_oe_o)
    else $error("bus line driven high or clock pin driven");

  AST_POWER_DOWN_PINS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $past(power_down_i) |-> (clock_port_pin_oe_o == app_pin_cfg_i.clock_pin_dir)
      && (data_port_pin_oe_o == app_pin_cfg_i.data_pin_dir))
    else $error("pins not under application setup in power-down");

  AST_PULLUP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(pull_ctrl_i.data_pin_pull_ctrl_a && pull_ctrl_i.data_pin_pull_ctrl_b) |=> !data_pin_pullup_o)
    else $error("pull-up on with a control bit clear");

  AST_RBF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    evt_pulse[EV_RX] |=> flags_q.rx_buffer_full_flag && (rx_data_q == $past(rx_byte_q)) ##1
    (data_rd_i ##1 !flags_q.rx_buffer_full_flag or !data_rd_i))
    else $error("receive flag or data wrong");

  AST_OVERFLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_ovf || tx_ovf |=> flags_q.overflow_flag)
    else $error("overflow not flagged");

  AST_MATCH_FLAGS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    evt_pulse[EV_AM] |=> flags_q.addr_match_flag && (flags_q.read_direction_flag == $past(rnw_q)))
    else $error("address match flags wrong");

  AST_STOP_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    evt_pulse[EV_STOP] |=> flags_q.stop_flag)
    else $error("stop not flagged");

  AST_TBF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    data_wr_i && !tbf_q |=> tbf_q && (tx_hold_q == $past(data_wdata_i)))
    else $error("transmit byte not held");

  COV_WRITE_BYTE: cover property (@(posedge bus_clk_i) disable iff (rst_i) wr_done);
  COV_READ_BYTE: cover property (@(posedge bus_clk_i) disable iff (rst_i) rd_done && tx_sh_q != IDLE_TX_BYTE);
  COV_STOP: cover property (@(posedge ref_clk_i) disable iff (rst_i) evt_pulse[EV_STOP]);
  COV_OVERFLOW: cover property (@(posedge ref_clk_i) disable iff (rst_i) rx_ovf);

endmodule : i2ctc_top

// [sim/i2ctc_master_model.sv]
// bus master model: makes the clock line and frames every transfer
// assumes pulled-up lines; outputs only pull low, release gives high
module i2ctc_master_model
  import i2ctc_pkg::*;
(
  // link clock
  input wire logic clk_i,
  // resolved data line
  input wire logic sda_i,
  // open-drain pulls
  output logic scl_low_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 6;

  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_cyc

  // also a repeated start when entered with the clock low
  task automatic start_cond();
    sda_low_o <= 1'b0;
    wait_cyc(HALF);
    scl_low_o <= 1'b0;
    wait_cyc(HALF);
    sda_low_o <= 1'b1;
    wait_cyc(HALF);
    scl_low_o <= 1'b1;
    wait_cyc(HALF);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o <= 1'b1;
    wait_cyc(HALF);
    scl_low_o <= 1'b0;
    wait_cyc(HALF);
    sda_low_o <= 1'b0;
    wait_cyc(HALF);
  endtask : stop_cond

  // a one is sent by releasing the line
  task automatic clock_bit(input logic b, output logic seen);
    sda_low_o <= ~b;
    wait_cyc(HALF);
    scl_low_o <= 1'b0;
    wait_cyc(HALF);
    seen = sda_i;
    scl_low_o <= 1'b1;
    wait_cyc(1);
  endtask : clock_bit

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = MSB_POS; i >= 0; i--)
      clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask : write_byte

  task automatic read_byte(input logic nack, output logic [7:0] b, output logic ninth);
    for (int i = MSB_POS; i >= 0; i--)
      clock_bit(1'b1, b[i]);
    clock_bit(nack, ninth);
  endtask : read_byte

endmodule : i2ctc_master_model

// [sim/i2ctc_top_tb.sv]
// self-checking bench of the serial-bus target controller
// assumes the master model on the link clock and external pull-ups
module i2ctc_top_tb
  import i2ctc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0, bus_clk = 1'b0, rst = 1'b1;
  logic en = 1'b0, gc = 1'b0, pd = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0] wdata = 8'h00, rdata;
  i2ctc_pull_type pull = '0;
  i2ctc_pin_cfg_type app = '0;
  i2ctc_status_type clr = '0, st;
  logic scl_oe, scl_o, sda_oe, sda_o, scl_pu, sda_pu, m_scl_low, m_sda_low;
  int num_errors = 0, checks_done = 0, cyc = 0;
  wire logic scl = ~(m_scl_low | (scl_oe & ~scl_o));
  wire logic sda = ~(m_sda_low | (sda_oe & ~sda_o));

  always #12.5 ref_clk = ~ref_clk;

  initial
  begin
    #7;
    forever #62.5 bus_clk = ~bus_clk;
  end

  i2ctc_top u_dut (.ref_clk_i(ref_clk), .bus_clk_i(bus_clk), .rst_i(rst), .bus_iface_enable_i(en),
    .general_call_enable_i(gc), .power_down_i(pd), .pull_ctrl_i(pull), .app_pin_cfg_i(app),
    .data_rd_i(rd), .data_wr_i(wr), .data_wdata_i(wdata), .bus_data_reg_o(rdata), .flag_clear_i(clr),
    .bus_status_reg_o(st), .clock_port_pin_i(scl), .clock_port_pin_o(scl_o), .clock_port_pin_oe_o(scl_oe),
    .clock_pin_pullup_o(scl_pu), .data_port_pin_i(sda), .data_port_pin_o(sda_o),
    .data_port_pin_oe_o(sda_oe), .data_pin_pullup_o(sda_pu));

  i2ctc_master_model u_master (.clk_i(bus_clk), .sda_i(sda), .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic sw_clear();
    clr <= '1;
    rd <= 1'b1;
    tick(1);
    clr <= '0;
    rd <= 1'b0;
    tick(1);
  endtask : sw_clear

  task automatic sw_write(input logic [7:0] d);
    wdata <= d;
    wr <= 1'b1;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask : sw_write

  always @(posedge bus_clk)
    if (sda_oe === 1'b1 && en && !pd)
      chk("sda drive level", 8'h00, sda_o);

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic ack, ninth;
    logic [7:0] got, tx, tx2;
    void'($urandom(32'h34bf));
    tick(16);
    rst <= 1'b0;
    app <= i2ctc_pin_cfg_type'(4'($urandom));
    tick(4);
    chk("app scl oe", app.clock_pin_dir, scl_oe);
    chk("app sda oe", app.data_pin_dir, sda_oe);
    app <= '0;
    for (int i = 0; i < 16; i++)
    begin
      pull <= i2ctc_pull_type'(i[3:0]);
      tick(3);
      chk("clock pullup", i[3] & i[2], scl_pu);
      chk("data pullup", i[1] & i[0], sda_pu);
    end
    u_master.start_cond();
    u_master.write_byte(OWN_ADDR_BYTE, ack);
    u_master.stop_cond();
    tick(10);
    chk("ack while off", 8'h00, ack);
    chk("match while off", 8'h00, st.addr_match_flag);
    en <= 1'b1;
    tick(60);
    chk("scl oe on", 8'h00, scl_oe);
    chk("sda oe idle", 8'h00, sda_oe);
    for (int k = 0; k < 2; k++)
    begin
      got = (k == 0) ? 8'h00 : (8'($urandom) & 8'hFE);
      if (got == OWN_ADDR_BYTE)
        got = 8'h6E;
      u_master.start_cond();
      u_master.write_byte(got, ack);
      u_master.stop_cond();
      tick(10);
      chk("foreign ack", 8'h00, ack);
      chk("foreign match", 8'h00, st.addr_match_flag);
    end
    gc <= 1'b1;
    u_master.start_cond();
    u_master.write_byte(GC_ADDR_BYTE, ack);
    u_master.stop_cond();
    tick(10);
    chk("gc ack", 8'h01, ack);
    chk("gc match", 8'h01, st.addr_match_flag);
    gc <= 1'b0;
    sw_clear();
    u_master.start_cond();
    u_master.write_byte(OWN_ADDR_BYTE, ack);
    chk("addr ack", 8'h01, ack);
    tick(10);
    chk("addr match", 8'h01, st.addr_match_flag);
    chk("write dir", 8'h00, st.read_direction_flag);
    for (int k = 0; k < 3; k++)
    begin
      tx = 8'($urandom);
      u_master.write_byte(tx, ack);
      chk("data ack", 8'h01, ack);
      tick(10);
      chk("rx full", 8'h01, st.rx_buffer_full_flag);
      chk("rx data", tx, rdata);
      chk("rx overflow", k == 2, st.overflow_flag);
      if (k == 0)
      begin
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
        chk("rx cleared", 8'h00, st.rx_buffer_full_flag);
      end
    end
    chk("stop early", 8'h00, st.stop_flag);
    u_master.stop_cond();
    tick(10);
    chk("stop", 8'h01, st.stop_flag);
    sw_clear();
    tx = 8'($urandom);
    tx2 = 8'($urandom);
    sw_write(tx);
    chk("tx full", 8'h01, st.tx_buffer_full_flag);
    sw_write(~tx);
    chk("tx overflow", 8'h01, st.overflow_flag);
    u_master.start_cond();
    u_master.write_byte(OWN_ADDR_BYTE | 8'h01, ack);
    chk("read addr ack", 8'h01, ack);
    tick(80);
    chk("read dir", 8'h01, st.read_direction_flag);
    chk("tx taken", 8'h00, st.tx_buffer_full_flag);
    sw_write(tx2);
    u_master.read_byte(1'b0, got, ninth);
    chk("read byte 1", tx, got);
    u_master.read_byte(1'b1, got, ninth);
    chk("read byte 2", tx2, got);
    chk("ninth released", 8'h01, ninth);
    u_master.stop_cond();
    tick(10);
    chk("read stop", 8'h01, st.stop_flag);
    pd <= 1'b1;
    app <= i2ctc_pin_cfg_type'(4'($urandom));
    tick(10);
    chk("pd scl oe", app.clock_pin_dir, scl_oe);
    chk("pd scl out", app.clock_pin_out, scl_o);
    chk("pd sda oe", app.data_pin_dir, sda_oe);
    chk("pd sda out", app.data_pin_out, sda_o);
    end_sim();
  end

endmodule : i2ctc_top_tb
